// ===== verilog/id_comm_flag_bank.v
// Control, status and result word bank of the identification-link unit,
// with an Avalon-MM slave, a scan divider and a level interrupt.
// Assumes the link engine runs on sys_clk_i and gives one-cycle pulses.
//
// How it works
// (RULE_01) Cancel bit aborts a pending automatic read or write, RUN mode only.
// (RULE_02) Flag reset clears all status flags but ready, and both result codes.
// (RULE_03) Test bit runs a test in PROGRAM mode; bit 09 picks write or read.
// (RULE_04) Log clear bits act in RUN or PROGRAM and drop back to zero alone.
// (RULE_05) Ready drops when an instruction runs and rises on its completion.
// (RULE_06) Completion flag sets as soon as carrier communication finishes.
// (RULE_07) General error bit is the OR of error flags 08 to 13.
// (RULE_08) Bit 06 shows low carrier battery, bit 07 a carrier check error.
// (RULE_09) Error flags set on detection, clear on flag reset or next instruction.
// (RULE_10) Result holds error code and instruction code; reads FFFF while busy.
// (RULE_11) Control word is sampled once per scan, at the overseeing phase.
// (RULE_12) Visible words refresh each scan or at completion, by setting.
// (RULE_13) Issue with no general error forces status 0000, result FFFF; blocks more.
// (RULE_14) Flag reset at completion: one normal update, then clear next scan.
// (RULE_15) After cancel, ready is set and status bits 01 to 15 are clear.
// (RULE_16) Cancel after the carrier is detected is ignored.
// (RULE_17) Software raises cancel only while ready is clear.
// (RULE_18) A cancelled transfer leaves its destination data untouched.
// (RULE_19) Reserved bits read as zero and ignore writes.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "id_comm_flag_bank_defines.vh"

module id_comm_flag_bank (
   // Clock and reset
   input wire sys_clk_i,
   input wire arst_n_i,
   // Avalon-MM slave, byte address
   input wire [9:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   // Link engine requests and results
   input wire cmd_issue_i,
   input wire [3:0] cmd_code_i,
   input wire cmd_auto_i,
   input wire carrier_found_i,
   input wire comm_done_i,
   input wire [5:0] comm_err_i,
   input wire [7:0] comm_err_code_i,
   input wire batt_low_i,
   input wire check_err_i,
   input wire general_error_flag_i,
   // Link engine controls
   output wire cmd_ready_o,
   output reg auto_cancel_o,
   output reg dest_commit_o,
   output reg test_run_o,
   output reg test_write_o,
   output reg log_clear_o,
   output reg stat_log_clear_o,
   output reg scan_tick_o,
   // Interrupt
   output wire irq_o
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_COMM = 3'b100;

   reg [15:0] ctrl_r;
   reg [7:0] cfg_r;
   reg [`IRQ_BITS-1:0] irq_stat_r;
   reg [`IRQ_BITS-1:0] irq_mask_r;
   reg [15:0] live_stat_r;
   reg [15:0] live_res_r;
   reg [15:0] vis_stat_r;
   reg [15:0] vis_res_r;
   reg [2:0] state_r;
   reg [3:0] cmd_r;
   reg fr_hold_r;
   reg ack_r;
   reg [9:0] scan_cnt_r;
   reg [15:0] done_stat_nxt;
   reg [15:0] done_res_nxt;
   reg [`IRQ_BITS-1:0] irq_evt;

   wire [1:0] mode = cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
   wire refresh_irq = cfg_r[`CFG_REFRESH];
   wire mode_run = (mode == `MODE_RUN);
   wire mode_prog = (mode == `MODE_PROGRAM);
   wire bus_req = avs_read_i | avs_write_i;
   wire wr_go = avs_write_i & ~ack_r;

   wire take_issue = cmd_issue_i & (state_r == ST_IDLE);
   // Control word is acted on as ctrl_r stands during the overseeing phase tick
   wire cancel_go = scan_tick_o & ctrl_r[`CTL_CANCEL] & mode_run & (state_r == ST_WAIT); // see RULE_01, RULE_16
   wire done_go = comm_done_i & (state_r == ST_COMM);
   wire flag_rst = scan_tick_o & ctrl_r[`CTL_FLAG_RST];

   function hit;
      input [9:0] addr;
      input [7:0] idx;
      begin
         hit = (addr[9:2] == idx);
      end
   endfunction

   // Status and result packed at the end of a transfer
   always @* begin
      done_stat_nxt = 16'h0000;
      done_stat_nxt[`ST_READY] = 1'b1; // see RULE_05
      done_stat_nxt[`ST_DONE] = 1'b1; // see RULE_06
      done_stat_nxt[`ST_ERR_HI:`ST_ERR_LO] = comm_err_i; // see RULE_09
      done_stat_nxt[`ST_ERR] = |comm_err_i; // see RULE_07
      done_stat_nxt[`ST_BATT] = batt_low_i; // see RULE_08
      done_stat_nxt[`ST_CHECK] = check_err_i; // see RULE_08
      done_res_nxt = {4'h0, cmd_r, (|comm_err_i) ? comm_err_code_i : 8'h00}; // see RULE_10
   end

   always @* begin
      irq_evt = {`IRQ_BITS{1'b0}};
      irq_evt[`IRQ_DONE] = done_go;
      irq_evt[`IRQ_CANCEL] = cancel_go;
      irq_evt[`IRQ_ERROR] = done_go & (|comm_err_i);
   end

   assign cmd_ready_o = (state_r == ST_IDLE) & ~cmd_issue_i; // see RULE_13
   assign avs_waitrequest_o = bus_req & ~ack_r;
   assign irq_o = |(irq_stat_r & irq_mask_r);

   // Scan divider; the tick marks the overseeing phase
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scan_cnt_r <= 10'h000;
         scan_tick_o <= 1'b0;
      end else if (scan_cnt_r == `SCAN_LAST) begin
         scan_cnt_r <= 10'h000;
         scan_tick_o <= 1'b1;
      end else begin
         scan_cnt_r <= scan_cnt_r + 10'h001;
         scan_tick_o <= 1'b0;
      end
   end

   // Bus slave: one wait cycle, read data registered before release
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_r <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         ack_r <= bus_req & ~ack_r;
         if (avs_read_i & ~ack_r) begin
            if (hit(avs_address_i, `IDX_CONTROL))
               avs_readdata_o <= {16'h0000, ctrl_r};
            else if (hit(avs_address_i, `IDX_STATUS))
               avs_readdata_o <= {16'h0000, vis_stat_r};
            else if (hit(avs_address_i, `IDX_RESULT))
               avs_readdata_o <= {16'h0000, vis_res_r};
            else if (hit(avs_address_i, `IDX_CONFIG))
               avs_readdata_o <= {24'h000000, cfg_r};
            else if (hit(avs_address_i, `IDX_IRQ_STAT))
               avs_readdata_o <= {29'h0, irq_stat_r};
            else if (hit(avs_address_i, `IDX_IRQ_MASK))
               avs_readdata_o <= {29'h0, irq_mask_r};
            else
               avs_readdata_o <= 32'h0000_0000;
         end
      end
   end

   // Software registers; a write lands on the edge that samples waitrequest low
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_r <= 16'h0000;
         cfg_r <= `CFG_RESET;
         irq_mask_r <= {`IRQ_BITS{1'b0}};
         irq_stat_r <= {`IRQ_BITS{1'b0}};
      end else begin
         // Log clear bits are consumed at the sample and fall back alone
         if (scan_tick_o) begin
            ctrl_r[`CTL_LOG_CLR] <= 1'b0; // see RULE_04
            ctrl_r[`CTL_STAT_CLR] <= 1'b0; // see RULE_04
         end
         if (ack_r & avs_write_i & hit(avs_address_i, `IDX_CONTROL))
            ctrl_r <= avs_writedata_i[15:0] & `CTL_WMASK; // see RULE_19
         if (ack_r & avs_write_i & hit(avs_address_i, `IDX_CONFIG))
            cfg_r <= avs_writedata_i[7:0] & 8'h13;
         if (ack_r & avs_write_i & hit(avs_address_i, `IDX_IRQ_MASK))
            irq_mask_r <= avs_writedata_i[`IRQ_BITS-1:0];
         // New events win over a same-cycle clear
         if (ack_r & avs_write_i & hit(avs_address_i, `IDX_IRQ_STAT))
            irq_stat_r <= (irq_stat_r & ~avs_writedata_i[`IRQ_BITS-1:0]) | irq_evt;
         else
            irq_stat_r <= irq_stat_r | irq_evt;
      end
   end

   // Scan-sampled control actions
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         test_run_o <= 1'b0;
         test_write_o <= 1'b0;
         log_clear_o <= 1'b0;
         stat_log_clear_o <= 1'b0;
      end else begin
         log_clear_o <= 1'b0;
         stat_log_clear_o <= 1'b0;
         if (scan_tick_o) begin
            test_run_o <= ctrl_r[`CTL_TEST] & mode_prog; // see RULE_03, RULE_11
            test_write_o <= ctrl_r[`CTL_TEST_WR]; // see RULE_03
            log_clear_o <= ctrl_r[`CTL_LOG_CLR] & (mode_run | mode_prog); // see RULE_04
            stat_log_clear_o <= ctrl_r[`CTL_STAT_CLR] & (mode_run | mode_prog); // see RULE_04
         end else if (!mode_prog) begin
            test_run_o <= 1'b0;
         end
      end
   end

   // Transfer sequencing, live words and the words software sees
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= ST_IDLE;
         cmd_r <= 4'h0;
         live_stat_r <= `ST_KEEP_READY;
         live_res_r <= `RES_CLEAR;
         vis_stat_r <= `ST_KEEP_READY;
         vis_res_r <= `RES_CLEAR;
         fr_hold_r <= 1'b0;
         auto_cancel_o <= 1'b0;
         dest_commit_o <= 1'b0;
      end else begin
         auto_cancel_o <= 1'b0;
         dest_commit_o <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (take_issue) begin
                  state_r <= cmd_auto_i ? ST_WAIT : ST_COMM;
                  cmd_r <= cmd_code_i;
                  live_stat_r <= `STAT_BUSY; // see RULE_05, RULE_07, RULE_09
                  live_res_r <= `RES_BUSY; // see RULE_10
                  fr_hold_r <= 1'b0;
                  if (!general_error_flag_i) begin
                     vis_stat_r <= `STAT_BUSY; // see RULE_13
                     vis_res_r <= `RES_BUSY; // see RULE_13
                  end
               end else if (flag_rst & ~fr_hold_r) begin
                  live_stat_r <= live_stat_r & `ST_KEEP_READY; // see RULE_02
                  live_res_r <= `RES_CLEAR; // see RULE_02
                  vis_stat_r <= vis_stat_r & `ST_KEEP_READY; // see RULE_02, RULE_14
                  vis_res_r <= `RES_CLEAR; // see RULE_02
               end else if (scan_tick_o & (~refresh_irq | fr_hold_r)) begin
                  vis_stat_r <= live_stat_r; // see RULE_12, RULE_14
                  vis_res_r <= live_res_r;
                  fr_hold_r <= 1'b0;
               end
            end
            ST_WAIT: begin
               // Cancel only bites before the carrier is seen
               if (cancel_go) begin
                  state_r <= ST_IDLE;
                  auto_cancel_o <= 1'b1;
                  live_stat_r <= `ST_KEEP_READY; // see RULE_15
                  live_res_r <= `RES_CLEAR;
                  vis_stat_r <= `ST_KEEP_READY; // see RULE_15
                  vis_res_r <= `RES_CLEAR;
               end else if (carrier_found_i) begin
                  state_r <= ST_COMM; // see RULE_16
               end
               if (scan_tick_o & ~refresh_irq & ~cancel_go) begin
                  vis_stat_r <= live_stat_r;
                  vis_res_r <= live_res_r;
               end
            end
            ST_COMM: begin
               if (done_go) begin
                  state_r <= ST_IDLE;
                  dest_commit_o <= 1'b1; // see RULE_18
                  live_stat_r <= done_stat_nxt; // see RULE_05, RULE_06
                  live_res_r <= done_res_nxt; // see RULE_10
                  // With flag reset on and scan refresh set, the next scan shows one normal update first
                  fr_hold_r <= ctrl_r[`CTL_FLAG_RST] & ~refresh_irq; // see RULE_14
                  if (refresh_irq) begin
                     vis_stat_r <= done_stat_nxt; // see RULE_12
                     vis_res_r <= done_res_nxt;
                  end
               end else if (scan_tick_o & ~refresh_irq) begin
                  vis_stat_r <= live_stat_r;
                  vis_res_r <= live_res_r;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // id_comm_flag_bank

// ===== verilog/id_comm_flag_bank_defines.vh
// Offsets, field positions, reset values and timing counts of the flag bank.
// Included by the design file only; holds definitions and nothing else.
`ifndef ID_COMM_FLAG_BANK_DEFINES_VH
`define ID_COMM_FLAG_BANK_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_CONTROL 8'he8
`define IDX_STATUS 8'he9
`define IDX_RESULT 8'hea
`define IDX_CONFIG 8'hf0
`define IDX_IRQ_STAT 8'hf1
`define IDX_IRQ_MASK 8'hf2

// Control word fields
`define CTL_CANCEL 0
`define CTL_FLAG_RST 1
`define CTL_TEST 8
`define CTL_TEST_WR 9
`define CTL_LOG_CLR 10
`define CTL_STAT_CLR 11
`define CTL_WMASK 16'h0f03

// Status word fields
`define ST_READY 0
`define ST_DONE 1
`define ST_ERR 2
`define ST_BATT 6
`define ST_CHECK 7
`define ST_ERR_LO 8
`define ST_ERR_HI 13
`define ST_KEEP_READY 16'h0001

// Result and status word values
`define RES_BUSY 16'hffff
`define RES_CLEAR 16'h0000
`define STAT_BUSY 16'h0000

// Config register fields: operating mode and refresh method
`define CFG_MODE_LO 0
`define CFG_MODE_HI 1
`define CFG_REFRESH 4
`define MODE_PROGRAM 2'h0
`define MODE_MONITOR 2'h1
`define MODE_RUN 2'h2
`define CFG_RESET 8'h00

// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_CANCEL 1
`define IRQ_ERROR 2
`define IRQ_BITS 3

// Scan period and its cycle count at the system clock
`define CLK_MHZ 10
`define SCAN_US 100
`define SCAN_CYCLES (`SCAN_US * `CLK_MHZ)
// Last count of the scan divider, one less than the scan length
`define SCAN_LAST 10'h3e7

`endif

// ===== dv/id_comm_flag_bank_assertions.sv
// Port checker for the flag bank: bus handshake, scan pacing, link pulses.
// Bound to every flag bank instance; one clock domain, async active-low reset.
`timescale 1ns/1ps
module id_comm_flag_bank_assertions (
   // Clock and reset
   input wire sys_clk_i,
   input wire arst_n_i,
   // Register bus
   input wire avs_read_i,
   input wire avs_write_i,
   input wire avs_waitrequest_o,
   // Link engine
   input wire cmd_issue_i,
   input wire comm_done_i,
   input wire cmd_ready_o,
   input wire auto_cancel_o,
   input wire dest_commit_o,
   input wire test_write_o,
   input wire log_clear_o,
   input wire scan_tick_o
);
   reg [10:0] gap_r;
   reg seen_r;
   // Cycles since last tick; first tick has no reference
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gap_r <= 11'h000;
         seen_r <= 1'b0;
      end else begin
         gap_r <= scan_tick_o ? 11'h000 : gap_r + 11'h001;
         seen_r <= seen_r | scan_tick_o;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   a_one_wait_cycle: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("access not answered after one wait cycle");
   a_idle_no_wait: assert property (!(avs_read_i | avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest high with no request");
   a_scan_period: assert property (scan_tick_o && seen_r |-> gap_r == 11'h3e7)
      else $error("scan tick spacing wrong");
   a_scan_pulse: assert property (scan_tick_o |=> !scan_tick_o [*8])
      else $error("scan tick longer than one cycle");
   a_issue_drops_ready: assert property (cmd_ready_o ##1 cmd_issue_i |=> !cmd_ready_o)
      else $error("ready stayed high after issue");
   a_commit_after_done: assert property (dest_commit_o |-> $past(comm_done_i))
      else $error("commit without completion");
   a_cancel_at_scan: assert property (auto_cancel_o |-> $past(scan_tick_o) && !dest_commit_o)
      else $error("cancel off scan or with commit");
   a_cancel_ready: assert property (auto_cancel_o && !cmd_issue_i |-> cmd_ready_o)
      else $error("not ready after cancel");
   a_log_pulse: assert property (log_clear_o |-> $past(scan_tick_o) ##1 !log_clear_o)
      else $error("log clear pulse wrong");
   a_test_dir_scan: assert property ($changed(test_write_o) |-> $past(scan_tick_o))
      else $error("test direction moved off scan");
endmodule // id_comm_flag_bank_assertions

bind id_comm_flag_bank id_comm_flag_bank_assertions u_id_comm_flag_bank_assertions (
   .sys_clk_i, .arst_n_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .cmd_issue_i,
   .comm_done_i, .cmd_ready_o, .auto_cancel_o, .dest_commit_o, .test_write_o, .log_clear_o, .scan_tick_o);

// ===== dv/link_engine_model.sv
// Link engine stand-in: one instruction per go request, carrier (auto only) then done.
// Runs on the bank clock; error lines carry junk outside the done pulse.
`timescale 1ns/1ps
module link_engine_model (
   // Clock and reset
   input wire sys_clk_i,
   input wire arst_n_i,
   // Bench requests
   input wire go_i,
   input wire auto_i,
   input wire [3:0] code_i,
   input wire [5:0] err_i,
   input wire [11:0] found_dly_i,
   // Design side
   input wire cmd_ready_i,
   input wire cancel_i,
   output reg cmd_issue_o,
   output reg [3:0] cmd_code_o,
   output reg cmd_auto_o,
   output reg carrier_found_o,
   output reg comm_done_o,
   output reg [5:0] comm_err_o,
   output reg [7:0] comm_err_code_o
);
   reg [1:0] state_r;
   reg [11:0] cnt_r;
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= 2'h0;
         cnt_r <= 12'h000;
         {cmd_issue_o, carrier_found_o, comm_done_o} <= 3'h0;
         {cmd_code_o, cmd_auto_o, comm_err_o, comm_err_code_o} <= 19'h00000;
      end else begin
         cmd_issue_o <= 1'b0;
         carrier_found_o <= 1'b0;
         comm_done_o <= 1'b0;
         comm_err_o <= ~err_i;
         comm_err_code_o <= ~{2'h0, err_i};
         case (state_r)
            2'h0: if (go_i) state_r <= 2'h1;
            2'h1: if (cmd_ready_i) begin
               cmd_issue_o <= 1'b1;
               cmd_code_o <= code_i;
               cmd_auto_o <= auto_i;
               cnt_r <= auto_i ? found_dly_i : 12'h014;
               state_r <= auto_i ? 2'h2 : 2'h3;
            end
            // Cancelled wait: no carrier, no data handed over
            2'h2: if (cancel_i) state_r <= 2'h0;
            else if (cnt_r == 12'h000) begin
               carrier_found_o <= 1'b1;
               cnt_r <= 12'h014;
               state_r <= 2'h3;
            end else cnt_r <= cnt_r - 12'h001;
            default: if (cnt_r == 12'h000) begin
               comm_done_o <= 1'b1;
               comm_err_o <= err_i;
               comm_err_code_o <= 8'h70 | {2'h0, err_i};
               state_r <= 2'h0;
            end else cnt_r <= cnt_r - 12'h001;
         endcase
      end
   end
endmodule // link_engine_model

// ===== dv/testbench.sv
// Self-checking bench: Avalon tasks, link engine model, scenario list.
// Assumes one wait cycle per access and a 1000-cycle scan.
`timescale 1ns/1ps
module testbench;
   reg sys_clk, arst_n, rd_q, wr_q, go, auto_op, warn, gen_err;
   reg [9:0] addr;
   reg [31:0] wdata, rdv;
   reg [5:0] op_err;
   reg [11:0] dly;
   wire [31:0] rdata;
   wire wreq, issue, op_auto, found, done, ready, cancel, commit, log_clr, tick, irq;
   wire [3:0] code;
   wire [5:0] err;
   wire [7:0] ecode;
   wire [3:0] ev = {commit, cancel, log_clr, tick};
   integer err_total, cmp_count, n;
   id_comm_flag_bank u_id_comm_flag_bank (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .avs_address_i(addr), .avs_read_i(rd_q),
      .avs_write_i(wr_q), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .cmd_issue_i(issue), .cmd_code_i(code), .cmd_auto_i(op_auto), .carrier_found_i(found),
      .comm_done_i(done), .comm_err_i(err), .comm_err_code_i(ecode), .batt_low_i(warn),
      .check_err_i(warn), .general_error_flag_i(gen_err), .cmd_ready_o(ready), .auto_cancel_o(cancel),
      .dest_commit_o(commit), .test_run_o(), .test_write_o(), .log_clear_o(log_clr),
      .stat_log_clear_o(), .scan_tick_o(tick), .irq_o(irq));
   link_engine_model u_link_engine_model (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .go_i(go), .auto_i(auto_op), .code_i(4'h3),
      .err_i(op_err), .found_dly_i(dly), .cmd_ready_i(ready), .cancel_i(cancel), .cmd_issue_o(issue),
      .cmd_code_o(code), .cmd_auto_o(op_auto), .carrier_found_o(found), .comm_done_o(done),
      .comm_err_o(err), .comm_err_code_o(ecode));
   task end_of_test;
      begin
         if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task hang;
      begin
         err_total = err_total + 1;
         $display("mismatch at %0t: wait ran out", $time);
         end_of_test;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Request held until the edge that samples waitrequest low
   task bus(input w, input [7:0] idx, input [15:0] d);
      begin
         @(posedge sys_clk);
         addr <= {idx, 2'h0};
         wdata <= {16'h0000, d};
         wr_q <= w;
         rd_q <= !w;
         n = 0;
         do begin
            @(posedge sys_clk);
            n = n + 1;
         end while (wreq !== 1'b0 && n < 20);
         if (wreq !== 1'b0) hang();
         rdv = rdata;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end
   endtask
   task rd(input [7:0] idx, input [15:0] exp);
      begin
         bus(1'b0, idx, 16'h0000);
         chk(rdv, {16'h0000, exp});
      end
   endtask
   task wait_ev(input integer sel);
      begin
         n = 0;
         do begin
            @(negedge sys_clk);
            n = n + 1;
         end while (ev[sel] !== 1'b1 && n < 5000);
         if (n == 5000) hang();
      end
   endtask
   task op(input a, input [5:0] e, input [11:0] f);
      begin
         @(posedge sys_clk);
         auto_op <= a;
         op_err <= e;
         dly <= f;
         go <= 1'b1;
         @(posedge sys_clk);
         go <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      err_total = 0;
      cmp_count = 0;
      {arst_n, rd_q, wr_q, go, auto_op, warn, gen_err} <= 7'h00;
      {addr, wdata, op_err, dly} <= 60'h0;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd(8'he8, 16'h0000);
      rd(8'he9, 16'h0001);
      rd(8'hea, 16'h0000);
      rd(8'h00, 16'h0000);
      bus(1'b1, 8'he8, 16'hffff);
      rd(8'he8, 16'h0f03);
      wait_ev(1);
      rd(8'he8, 16'h0303);
      bus(1'b1, 8'he8, 16'h0000);
      bus(1'b1, 8'hf0, 16'h0012);
      bus(1'b1, 8'hf2, 16'h0007);
      op(1'b0, 6'h00, 12'h000);
      rd(8'he9, 16'h0000);
      rd(8'hea, 16'hffff);
      wait_ev(3);
      rd(8'he9, 16'h0003);
      rd(8'hea, 16'h0300);
      chk({31'h0, irq}, 32'h1);
      rd(8'hf1, 16'h0001);
      bus(1'b1, 8'hf1, 16'h0007);
      @(negedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      @(posedge sys_clk);
      warn <= 1'b1;
      op(1'b0, 6'h04, 12'h000);
      wait_ev(3);
      rd(8'he9, 16'h04c7);
      rd(8'hea, 16'h0374);
      bus(1'b1, 8'he8, 16'h0002);
      wait_ev(0);
      rd(8'he9, 16'h0001);
      rd(8'hea, 16'h0000);
      bus(1'b1, 8'he8, 16'h0000);
      op(1'b1, 6'h00, 12'hfff);
      rd(8'he9, 16'h0000);
      bus(1'b1, 8'he8, 16'h0001);
      wait_ev(2);
      rd(8'he9, 16'h0001);
      rd(8'hea, 16'h0000);
      @(posedge sys_clk);
      gen_err <= 1'b1;
      op(1'b0, 6'h00, 12'h000);
      rd(8'he9, 16'h0001);
      wait_ev(3);
      rd(8'he9, 16'h00c3);
      bus(1'b1, 8'he8, 16'h0000);
      end_of_test;
   end
endmodule // testbench
